// ==== verilog/kwu_defines.svh ====
// Constants for the key-on wakeup block: register offset, field layout, reset value.
// Assumes inclusion by bare name from the design files.
`ifndef KWU_DEFINES_SVH
`define KWU_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (enable word index and byte addresses)
// ----------------------------------------------------------------------------
// Enable register index; each index is one aligned word, so its byte address is four times it
`define KWU_ENABLE_IDX      12'h031
`define KWU_ENABLE_OFS      12'h0c4
`define KWU_STATUS_OFS      12'h040
`define KWU_CTRL_OFS        12'h044

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define KWU_EN_LSB          4
`define KWU_EN_MSB          7
`define KWU_EN_RESET        4'h0
`define KWU_CTRL_RELM_BIT   0
`define KWU_CTRL_ENTER_BIT  1
`define KWU_RELM_RESET      1'b1
`define KWU_NKEYS           4

// ----------------------------------------------------------------------------
// Warm-up length in clock cycles
// ----------------------------------------------------------------------------
`define KWU_WARMUP_CYCLES   16'h0100

`endif

// ==== verilog/kwu_pkg.sv ====
// Types shared by the key-on wakeup block.
// Assumes kwu_defines.svh is on the include path.
`include "kwu_defines.svh"

package kwu_pkg;

  typedef enum logic [1:0] {
    KWU_RUN    = 2'b00,
    KWU_STOP   = 2'b01,
    KWU_WARMUP = 2'b11
  } kwu_state_e;

  typedef struct packed {
    logic       sel;
    logic       enable;
    logic       write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } kwu_apb_req_s;

  typedef struct packed {
    logic       ready;
    logic [31:0] rdata;
    logic       slverr;
  } kwu_apb_rsp_s;

endpackage

// ==== verilog/kwu_sync.sv ====
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes pins are steady for several clock cycles.
`timescale 1ns/1ns
`default_nettype none

module kwu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // kwu_sync

`default_nettype wire

// ==== verilog/kwu_apb_slave.sv ====
// APB slave front end: decodes enable and control writes into strobes, status and control reads into read data.
// Assumes a single-cycle access phase (pready always high).
`timescale 1ns/1ns
`default_nettype none
`include "kwu_defines.svh"

module kwu_apb_slave (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Bus
  input  wire kwu_pkg::kwu_apb_req_s req,
  output kwu_pkg::kwu_apb_rsp_s      rsp,
  // Register side
  output logic                     wr_enable,
  output logic                     wr_ctrl,
  output logic [31:0]              wdata,
  input  wire logic [31:0]         status_word,
  input  wire logic [31:0]         ctrl_word
);
  import kwu_pkg::*;

  logic access;
  logic mapped;

  assign access = req.sel && req.enable;
  assign mapped = (req.addr == `KWU_ENABLE_OFS) || (req.addr == `KWU_STATUS_OFS) ||
                  (req.addr == `KWU_CTRL_OFS);
  assign wr_enable = access && req.write && (req.addr == `KWU_ENABLE_OFS);
  assign wr_ctrl   = access && req.write && (req.addr == `KWU_CTRL_OFS);
  assign wdata     = req.wdata;

  always_comb begin
    rsp.ready  = 1'b1;
    rsp.slverr = access && !mapped;
    rsp.rdata  = 32'h0;
    if (access && !req.write) begin
      case (req.addr)
        `KWU_STATUS_OFS: rsp.rdata = status_word;
        `KWU_CTRL_OFS:   rsp.rdata = ctrl_word;
        default:         rsp.rdata = 32'h0;
      endcase
    end
  end

endmodule // kwu_apb_slave

`default_nettype wire

// ==== verilog/kwu_top.sv ====
// Key-on wakeup: releases standby on the release pin or, in level mode, enabled key pins.
// Assumes an APB master on pclk and asynchronous pins from key switches.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "kwu_defines.svh"

module kwu_top (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Pins
  input  wire logic                  stop_release_pin,
  input  wire logic [`KWU_NKEYS-1:0] key_wake_pins,
  // Power control
  output logic                       standby_q,
  output logic                       warmup_q,
  output logic                       wake_request_async
);
  import kwu_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic key_request(input logic [3:0] pins, input logic [3:0] en);
    key_request = |(~pins & en);
  endfunction

  // --------------------------------------------------------------------------
  // Bus
  // --------------------------------------------------------------------------
  kwu_apb_req_s req;
  kwu_apb_rsp_s rsp;
  logic         wr_enable;
  logic         wr_ctrl;
  logic [31:0]  wdata;
  logic [31:0]  status_word;
  logic [31:0]  ctrl_word;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  kwu_apb_slave u_apb (
    .pclk        (pclk),
    .presetn     (presetn),
    .req         (req),
    .rsp         (rsp),
    .wr_enable   (wr_enable),
    .wr_ctrl     (wr_ctrl),
    .wdata       (wdata),
    .status_word (status_word),
    .ctrl_word   (ctrl_word)
  );

  // Responses leave through flops: one wait state, answer stands while pready is high
  logic acc_c;
  logic wr_enable_c;
  logic wr_ctrl_c;

  assign acc_c       = psel && penable;
  assign wr_enable_c = wr_enable && pready;
  assign wr_ctrl_c   = wr_ctrl && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= rsp.ready && acc_c && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= rsp.rdata;
      pslverr <= rsp.slverr;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [3:0] key_en_q;
  logic       relm_q;
  logic       enter_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_en_q <= `KWU_EN_RESET;
    end else if (wr_enable_c) begin
      key_en_q <= wdata[`KWU_EN_MSB:`KWU_EN_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relm_q <= `KWU_RELM_RESET;
    end else if (wr_ctrl_c) begin
      relm_q <= wdata[`KWU_CTRL_RELM_BIT];
    end
  end

  assign enter_pulse = wr_ctrl_c && wdata[`KWU_CTRL_ENTER_BIT];

  // --------------------------------------------------------------------------
  // Synchronised pins
  // --------------------------------------------------------------------------
  logic       rel_s;
  logic [3:0] key_s;
  logic       rel_prev_q;

  kwu_sync #(.W(5)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({stop_release_pin, key_wake_pins}),
    .sync_out ({rel_s, key_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_prev_q <= 1'b1;
    end else begin
      rel_prev_q <= rel_s;
    end
  end

  logic level_req;
  logic edge_req;
  logic release_req;

  assign level_req   = rel_s | key_request(key_s, key_en_q);
  assign edge_req    = rel_s & ~rel_prev_q;
  assign release_req = relm_q ? level_req : edge_req;

  // Combined request for the power controller, keys gated by level mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request_async <= 1'b0;
    end else begin
      wake_request_async <= rel_s | (relm_q & key_request(key_s, key_en_q));
    end
  end

  // --------------------------------------------------------------------------
  // Standby sequencer
  // --------------------------------------------------------------------------
  kwu_state_e state_q;
  logic [15:0] warm_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= KWU_RUN;
    end else begin
      case (state_q)
        KWU_RUN: begin
          if (enter_pulse) begin
            // Present request skips standby (edge mode: pin already high)
            if (relm_q ? level_req : rel_s) begin
              state_q <= KWU_WARMUP;
            end else begin
              state_q <= KWU_STOP;
            end
          end
        end
        KWU_STOP: begin
          if (release_req) begin
            state_q <= KWU_WARMUP;
          end
        end
        KWU_WARMUP: begin
          if (warm_cnt_q == 16'h0001) begin
            state_q <= KWU_RUN;
          end
        end
        default: state_q <= KWU_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cnt_q <= 16'h0;
    end else if (state_q != KWU_WARMUP) begin
      warm_cnt_q <= `KWU_WARMUP_CYCLES;
    end else if (warm_cnt_q != 16'h0) begin
      warm_cnt_q <= warm_cnt_q - 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs and status
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_q <= 1'b0;
      warmup_q  <= 1'b0;
    end else begin
      standby_q <= (state_q == KWU_STOP);
      warmup_q  <= (state_q == KWU_WARMUP);
    end
  end

  assign status_word = {24'h0, rel_s, key_s, 1'b0, state_q};
  assign ctrl_word   = {31'h0, relm_q};

endmodule // kwu_top

`default_nettype wire

// ==== sim/kwu_top_assertions.sv ====
// Checker for the kwu_top ports, bound to every instance.
// Assumes an APB master that holds requests and slow pins.
`timescale 1ns/1ns
`default_nettype none
`include "kwu_defines.svh"

module kwu_top_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and power state
  input wire logic        stop_release_pin,
  input wire logic [3:0]  key_wake_pins,
  input wire logic        standby_q,
  input wire logic        warmup_q,
  input wire logic        wake_request_async
);
  logic       mode_q;
  logic [3:0] en_q;
  logic [8:0] wcnt_q;
  wire        acc = psel && penable && pready;
  wire        ctl_wr = acc && pwrite && paddr == `KWU_CTRL_OFS;
  wire        lvl_req = stop_release_pin || (mode_q && |(en_q & ~key_wake_pins));

  // Mirror of the write-only key enables and the readable mode bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `KWU_RELM_RESET;
      en_q   <= `KWU_EN_RESET;
    end else if (acc && pwrite && paddr == `KWU_ENABLE_OFS) begin
      en_q <= pwdata[7:4];
    end else if (ctl_wr) begin
      mode_q <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt_q <= 9'h000;
    else wcnt_q <= warmup_q ? wcnt_q + 9'h001 : 9'h000;
  end

  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_unmapped_refused: assert property (
    acc && !(paddr inside {`KWU_ENABLE_OFS, `KWU_STATUS_OFS, `KWU_CTRL_OFS}) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_enable_write_only: assert property (
    acc && !pwrite && paddr == `KWU_ENABLE_OFS |-> prdata == 32'h0 && !pslverr)
    else $error("enable register read back");
  a_states_exclusive: assert property (!(standby_q && warmup_q))
    else $error("standby and warm-up together");
  a_stop_to_warm: assert property ($fell(standby_q) |-> ##[0:1] warmup_q)
    else $error("standby left without warm-up");
  a_level_release: assert property (
    (standby_q && mode_q && lvl_req) [*3] |-> ##[0:4] !standby_q)
    else $error("level request did not release");
  a_edge_hold: assert property (
    (standby_q && !mode_q && !stop_release_pin) [*6] |=> standby_q)
    else $error("edge mode released without rising edge");
  a_warm_length: assert property (
    $fell(warmup_q) |-> wcnt_q >= 9'h0ff && wcnt_q <= 9'h101)
    else $error("warm-up length wrong");
  a_skip_entry: assert property (
    ctl_wr && pwdata[1] && lvl_req && $past(lvl_req, 3) |-> (!standby_q [*6]) and (##5 warmup_q))
    else $error("entry with request did not skip");
  a_request_flag: assert property (lvl_req [*4] |-> wake_request_async)
    else $error("combined request missing");

  c_key_wake: cover property (standby_q && mode_q && |(en_q & ~key_wake_pins));
  c_edge_wake: cover property (standby_q && !mode_q && $rose(stop_release_pin));
  c_skip: cover property (ctl_wr && pwdata[1] && lvl_req);
endmodule // kwu_top_checker

bind kwu_top kwu_top_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .stop_release_pin, .key_wake_pins, .standby_q, .warmup_q, .wake_request_async);
`default_nettype wire

// ==== sim/kwu_keys_model.sv ====
// Key switches and release line outside the device.
// Assumes the bench changes press and rel_req just after pclk edges.
`timescale 1ns/1ns
`default_nettype none

module kwu_keys_model (
  // Requests from the bench
  input  wire logic       rel_req,
  input  wire logic [3:0] press,
  // Pins
  output logic            stop_release_pin,
  output logic [3:0]      key_wake_pins
);
  // Release line rests low unless a wake is wanted
  assign stop_release_pin = rel_req;
  // Open keys pulled up, so enabled pins read high before standby
  assign key_wake_pins = ~press;
endmodule // kwu_keys_model
`default_nettype wire

// ==== sim/tb_key_on_wakeup_release.sv ====
// Self-checking bench for kwu_top with a key switch model.
// Assumes the package, design, checker and model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "kwu_defines.svh"

module tb_key_on_wakeup_release;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, rel_req = 1'b0, rel_pin, standby_q, warmup_q, wake_req;
  logic [3:0]  press = 4'h0, keys;
  int          fail_count = 0, num_checks = 0;

  always #20 pclk = ~pclk;

  kwu_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stop_release_pin(rel_pin), .key_wake_pins(keys), .standby_q, .warmup_q, .wake_request_async(wake_req));
  kwu_keys_model u_keys (.rel_req, .press, .stop_release_pin(rel_pin), .key_wake_pins(keys));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, exp_d, input logic exp_e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!wr) chk(prdata, exp_d);
    chk({31'h0, pslverr}, {31'h0, exp_e});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic st(input logic sb, input logic wu, input int n);
    repeat (n) @(posedge pclk);
    chk({30'h0, standby_q, warmup_q}, {30'h0, sb, wu});
  endtask

  task automatic wake(input logic by_pin, input logic [3:0] k);
    rel_req <= by_pin;
    press <= k;
    st(1'b0, 1'b1, 6);
    if (by_pin || k != 4'h0) chk({31'h0, wake_req}, 32'h1);
    rel_req <= 1'b0;
    press <= 4'h0;
    st(1'b0, 1'b0, 260);
    chk({31'h0, wake_req}, 32'h0);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, `KWU_ENABLE_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `KWU_ENABLE_OFS, 32'hff, 32'h0, 1'b0);
    apb(1'b0, `KWU_ENABLE_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 12'h100, 32'hffffffff, 32'h0, 1'b1);
    apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
    $display("test registers done");
  endtask

  task automatic t_keys;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `KWU_ENABLE_OFS, 32'h10 << i, 32'h0, 1'b0);
      apb(1'b1, `KWU_CTRL_OFS, 32'h3, 32'h0, 1'b0);
      st(1'b1, 1'b0, 4);
      press <= 4'h1 << ((i + 1) % 4);
      st(1'b1, 1'b0, 8);
      wake(i == 4, 4'h1 << i);
    end
    $display("test level release done");
  endtask

  task automatic t_edge;
    apb(1'b1, `KWU_CTRL_OFS, 32'h0, 32'h0, 1'b0);
    rel_req <= 1'b1;
    apb(1'b1, `KWU_CTRL_OFS, 32'h2, 32'h0, 1'b0);
    st(1'b0, 1'b1, 4);
    wake(1'b0, 4'h0);
    apb(1'b1, `KWU_CTRL_OFS, 32'h2, 32'h0, 1'b0);
    st(1'b1, 1'b0, 10);
    wake(1'b1, 4'h0);
    $display("test edge release done");
  endtask

  task automatic t_skip;
    apb(1'b1, `KWU_CTRL_OFS, 32'h1, 32'h0, 1'b0);
    apb(1'b1, `KWU_ENABLE_OFS, 32'h80, 32'h0, 1'b0);
    press <= 4'h8;
    repeat (4) @(posedge pclk);
    apb(1'b1, `KWU_CTRL_OFS, 32'h3, 32'h0, 1'b0);
    st(1'b0, 1'b1, 4);
    presetn <= 1'b0;
    st(1'b0, 1'b0, 2);
    presetn <= 1'b1;
    press <= 4'h0;
    apb(1'b0, `KWU_STATUS_OFS, 32'h0, 32'h78, 1'b0);
    $display("test skip and reset done");
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_keys;
    t_edge;
    t_skip;
    wrap_up;
  end

  initial begin
    #400000;
    fail_count++;
    wrap_up;
  end
endmodule // tb_key_on_wakeup_release
`default_nettype wire
